/* src/fsb_pkg.sv */
// Constants shared by the fault status block
package fsb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = $clog2(FRAME_BITS);
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam int POS_RAIL = 8;
  localparam int POS_COMM = 9;
  localparam int POS_ILIM = 10;
  localparam int EV_RAIL = 0;
  localparam int EV_COMM = 1;
  localparam int EV_ILIM = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] IRQ_STAT_RST = 3'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic FLAG_RST = 1'b0;
endpackage

/* src/fsb_frame_check.sv */
// Serial frame checker: clock count and check code result at chip select release
module fsb_frame_check
  import fsb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic crc_mismatch,
  output logic frame_bad,
  output logic frame_good
);
  import fsb_pkg::*;

  logic cs_d_reg, cs_d_next;
  logic sclk_d_reg, sclk_d_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic any_reg, any_next;
  logic bad_reg, bad_next;
  logic good_reg, good_next;
  logic cs_rise, cs_fall, sclk_rise;

  always_comb begin
    cs_rise = cs_n & ~cs_d_reg;
    cs_fall = ~cs_n & cs_d_reg;
    sclk_rise = sclk & ~sclk_d_reg & ~cs_n;
    cs_d_next = cs_n;
    sclk_d_next = sclk;
    cnt_next = cnt_reg;
    any_next = any_reg;
    if (cs_fall) begin
      cnt_next = '0;
      any_next = 1'b0;
    end else if (sclk_rise) begin
      cnt_next = cnt_reg + 1'b1;
      any_next = 1'b1;
    end
    // Count wraps every frame word, so zero means a whole multiple
    bad_next = cs_rise & ((cnt_reg != '0) | crc_mismatch);
    good_next = cs_rise & any_reg & (cnt_reg == '0) & ~crc_mismatch;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      cnt_reg <= '0;
      any_reg <= 1'b0;
      bad_reg <= 1'b0;
      good_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_d_next;
      sclk_d_reg <= sclk_d_next;
      cnt_reg <= cnt_next;
      any_reg <= any_next;
      bad_reg <= bad_next;
      good_reg <= good_next;
    end
  end

  assign frame_bad = bad_reg;
  assign frame_good = good_reg;

  a_count_check: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n && !cs_d_reg && cnt_reg != '0) |=> frame_bad)
    else $error("odd clock count missed");
  a_crc_check: assert property (@(posedge core_clk) disable iff (rst)
    (cs_n && !cs_d_reg && crc_mismatch) |=> (frame_bad && !frame_good))
    else $error("crc miss");
endmodule

/* src/fsb_top.sv */
// Fault status bits: communication, input rail and current limit flags
// Behaviour
// - Clock count not multiple of 16 faults
// - Check code mismatch sets comm fault
// - Valid command then second status read clears
// - Any input rail over/undervoltage sets rail fault
//
// Strobed register access and the register offsets were chosen for this implementation.
module fsb_top
  import fsb_pkg::*;
#(
  parameter int RAILS = 2
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic crc_mismatch,
  input wire logic second_status_read,
  input wire logic [RAILS-1:0] rail_ov,
  input wire logic [RAILS-1:0] rail_uv,
  input wire logic ilimit_active,
  input wire logic [fsb_pkg::ADDR_W-1:0] addr,
  input wire logic [fsb_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [fsb_pkg::DATA_W-1:0] rdata,
  output logic irq,
  output logic comm_fault,
  output logic input_side_rail_fault,
  output logic regulator_current_limit_flag
);
  import fsb_pkg::*;

  logic frame_bad, frame_good;
  logic armed_reg, armed_next;
  logic comm_reg, comm_next;
  logic rail_reg, rail_next;
  logic ilim_reg, ilim_next;
  logic [EV_W-1:0] istat_reg, istat_next;
  logic [EV_W-1:0] mask_reg, mask_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic st2_rd, rail_ev;
  logic [EV_W-1:0] events;

  fsb_frame_check u_frame (
    .core_clk(core_clk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk(sclk),
    .crc_mismatch(crc_mismatch),
    .frame_bad(frame_bad),
    .frame_good(frame_good)
  );

  function automatic logic [DATA_W-1:0] status_word(input logic r, input logic c,
                                                    input logic i);
    logic [DATA_W-1:0] w;
    w = '0;
    w[POS_RAIL] = r;
    w[POS_COMM] = c;
    w[POS_ILIM] = i;
    return w;
  endfunction

  always_comb begin
    // The second status word may be read over the serial link or the local port
    st2_rd = second_status_read | (rd_en & (addr == OFF_STATUS));
    rail_ev = |(rail_ov | rail_uv);
    armed_next = armed_reg;
    comm_next = comm_reg;
    // A bad frame always wins and forgets any earlier good command
    if (frame_bad) begin
      comm_next = 1'b1;
      armed_next = 1'b0;
    end else if (armed_reg && st2_rd) begin
      comm_next = 1'b0;
      armed_next = 1'b0;
    end else if (frame_good) begin
      armed_next = 1'b1;
    end
    // Rail and current limit flags hold until a status read with the cause gone
    rail_next = rail_ev ? 1'b1 : (st2_rd ? 1'b0 : rail_reg);
    ilim_next = ilimit_active ? 1'b1 : (st2_rd ? 1'b0 : ilim_reg);
  end

  always_comb begin
    events = '0;
    events[EV_RAIL] = rail_ev & ~rail_reg;
    events[EV_COMM] = frame_bad;
    events[EV_ILIM] = ilimit_active & ~ilim_reg;
    mask_next = mask_reg;
    istat_next = istat_reg;
    if (wr_en && addr == OFF_IRQ_MASK) begin
      mask_next = wdata[EV_W-1:0];
    end
    if (wr_en && addr == OFF_IRQ_STAT) begin
      istat_next = istat_reg & ~wdata[EV_W-1:0];
    end
    // Set beats a same-cycle write-one-to-clear
    istat_next = istat_next | events;
    irq_next = |(istat_next & mask_next);
    rdata_next = '0;
    if (rd_en) begin
      unique case (addr)
        OFF_STATUS: rdata_next = status_word(rail_reg, comm_reg, ilim_reg);
        OFF_IRQ_STAT: rdata_next = {{(DATA_W-EV_W){1'b0}}, istat_reg};
        OFF_IRQ_MASK: rdata_next = {{(DATA_W-EV_W){1'b0}}, mask_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
      comm_reg <= FLAG_RST;
      rail_reg <= FLAG_RST;
      ilim_reg <= FLAG_RST;
      istat_reg <= IRQ_STAT_RST;
      mask_reg <= IRQ_MASK_RST;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      comm_reg <= comm_next;
      rail_reg <= rail_next;
      ilim_reg <= ilim_next;
      istat_reg <= istat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign comm_fault = comm_reg;
  assign input_side_rail_fault = rail_reg;
  assign regulator_current_limit_flag = ilim_reg;

  // A good command, then a read of the second status word, no bad frame between
  sequence s_good_frame;
    frame_good && !frame_bad;
  endsequence

  sequence s_clear_read;
    st2_rd && !frame_bad;
  endsequence

  sequence s_cmd_then_read;
    (!frame_bad) throughout (s_good_frame ##[1:40] s_clear_read);
  endsequence

  // Frame outcome must reach the fault flag and the arming state
  a_bad_sets_comm: assert property (@(posedge core_clk) disable iff (rst)
    frame_bad |=> comm_fault)
    else $error("bad frame did not set fault");

  a_bad_disarms: assert property (@(posedge core_clk) disable iff (rst)
    frame_bad |=> !armed_reg)
    else $error("bad frame left command armed");

  a_good_arms: assert property (@(posedge core_clk) disable iff (rst)
    (frame_good && !st2_rd) |=> armed_reg)
    else $error("good frame did not arm clear");

  a_clear_after_cmd: assert property (@(posedge core_clk) disable iff (rst)
    s_cmd_then_read |=> !comm_fault)
    else $error("fault not cleared by command then read");

  // Without a good command first, no read may clear the fault
  a_no_early_clear: assert property (@(posedge core_clk) disable iff (rst)
    (comm_fault && !armed_reg) |=> comm_fault)
    else $error("fault cleared early");

  a_clear_needs_read: assert property (@(posedge core_clk) disable iff (rst)
    $fell(comm_fault) |-> ($past(st2_rd) && $past(armed_reg)))
    else $error("fault cleared without armed read");

  a_rail_sets: assert property (@(posedge core_clk) disable iff (rst)
    rail_ev |=> input_side_rail_fault)
    else $error("rail event not flagged");

  a_rail_hold: assert property (@(posedge core_clk) disable iff (rst)
    (input_side_rail_fault && !st2_rd) |=> input_side_rail_fault)
    else $error("rail flag dropped without read");

  // One check per rail input, so a rail left out of the fault OR shows up
  for (genvar g = 0; g < RAILS; g++) begin : gen_rail_chk
    a_rail_each: assert property (@(posedge core_clk) disable iff (rst)
      (rail_ov[g] || rail_uv[g]) |=> input_side_rail_fault)
      else $error("rail input not flagged");
  end

  // Current limit flag latches like the rail flag
  a_ilim_sets: assert property (@(posedge core_clk) disable iff (rst)
    ilimit_active |=> regulator_current_limit_flag)
    else $error("current limit not flagged");

  // Flags must read as clear on the first edge after reset
  a_reset_zero: assert property (@(posedge core_clk)
    $fell(rst) |-> !comm_fault && !input_side_rail_fault && !regulator_current_limit_flag)
    else $error("flag not clear after reset");

  a_status_read: assert property (@(posedge core_clk) disable iff (rst)
    (rd_en && addr == OFF_STATUS) |=> rdata == status_word($past(rail_reg), $past(comm_reg),
    $past(ilim_reg)))
    else $error("status word mismatch");

  // Writes to the status word must leave every flag alone
  a_status_ro: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && addr == OFF_STATUS && !frame_bad && !rail_ev && !ilimit_active && !st2_rd)
    |=> $stable(comm_fault) && $stable(input_side_rail_fault)
    && $stable(regulator_current_limit_flag))
    else $error("flag written");

  // Read data returns to zero when no read is pending
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !rd_en |=> (rdata == '0))
    else $error("read data not idle");

  // Interrupt output follows the registered status and mask
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    irq == |(istat_reg & mask_reg))
    else $error("irq level wrong");
endmodule

/* bench/fsb_host_model.sv */
// Host serial controller model: frames of counted clocks and status word reads
module fsb_host_model (
  input wire logic core_clk,
  output logic cs_n,
  output logic sclk,
  output logic crc_mismatch,
  output logic second_status_read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    crc_mismatch = 1'b1;
    second_status_read = 1'b0;
  end
  // Clock idles low outside frames; check code held past the release edge
  task automatic frame(input int n, input logic bad);
    @(posedge core_clk) cs_n <= 1'b0;
    repeat (n) begin
      repeat (2) @(posedge core_clk) sclk <= 1'b1;
      repeat (2) @(posedge core_clk) sclk <= 1'b0;
    end
    @(posedge core_clk) cs_n <= 1'b1;
    crc_mismatch <= bad;
    repeat (2) @(posedge core_clk);
    crc_mismatch <= ~bad;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic read_second_status();
    @(posedge core_clk) second_status_read <= 1'b1;
    @(posedge core_clk) second_status_read <= 1'b0;
  endtask
endmodule

/* bench/tb_fsb_top.sv */
// Testbench for the fault status bits block
module tb_fsb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fsb_pkg::*;
  logic core_clk, rst, cs_n, sclk, crc_mismatch, second_status_read, ilimit_active, wr_en, rd_en;
  logic irq, comm_fault, input_side_rail_fault, regulator_current_limit_flag;
  logic [1:0] rail_ov, rail_uv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rd_val;
  int errors = 0;
  int checked = 0;
  fsb_top #(.RAILS(2)) dut_u (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .crc_mismatch(crc_mismatch), .second_status_read(second_status_read), .rail_ov(rail_ov),
    .rail_uv(rail_uv), .ilimit_active(ilimit_active), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .comm_fault(comm_fault),
    .input_side_rail_fault(input_side_rail_fault),
    .regulator_current_limit_flag(regulator_current_limit_flag));
  fsb_host_model host_u (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
    .crc_mismatch(crc_mismatch), .second_status_read(second_status_read));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk) wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk) wr_en <= 1'b0;
  endtask
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge core_clk) rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk) rd_en <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  initial begin
    {rst, ilimit_active, wr_en, rd_en} = 4'hF;
    {ilimit_active, wr_en, rd_en} = 3'h0;
    {rail_ov, rail_uv, addr, wdata} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reg_read(OFF_STATUS); chk_word(rd_val, 32'h0);
    reg_read(OFF_IRQ_MASK); chk_word(rd_val, 32'h0);
    $display("test reset done");
    host_u.frame(15, 1'b0); settle(); chk_flag(comm_fault, 1'b1);
    host_u.frame(16, 1'b0); settle(); chk_flag(comm_fault, 1'b1);
    host_u.read_second_status(); settle(); chk_flag(comm_fault, 1'b0);
    host_u.frame(17, 1'b0); reg_read(OFF_STATUS); chk_word(rd_val, 32'h1 << POS_COMM);
    host_u.frame(16, 1'b0); reg_read(OFF_STATUS); settle(); chk_flag(comm_fault, 1'b0);
    host_u.frame(32, 1'b1); settle(); chk_flag(comm_fault, 1'b1);
    $display("test comm done");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) if (i < 2) rail_ov[i] <= 1'b1; else rail_uv[i-2] <= 1'b1;
      @(posedge core_clk) {rail_ov, rail_uv} <= '0;
      settle(); chk_flag(input_side_rail_fault, 1'b1);
      reg_read(OFF_STATUS); chk_word(rd_val, 32'h1 << POS_RAIL | 32'h1 << POS_COMM);
      settle(); chk_flag(input_side_rail_fault, 1'b0);
    end
    $display("test rail done");
    reg_write(OFF_IRQ_MASK, 32'h1 << EV_ILIM); settle(); chk_flag(irq, 1'b0);
    reg_write(OFF_IRQ_STAT, 32'h7);
    @(posedge core_clk) ilimit_active <= 1'b1;
    @(posedge core_clk) ilimit_active <= 1'b0;
    settle(); chk_flag(regulator_current_limit_flag, 1'b1);
    chk_flag(irq, 1'b1);
    reg_read(OFF_IRQ_STAT); chk_word(rd_val, 32'h1 << EV_ILIM);
    reg_write(OFF_IRQ_STAT, 32'h1 << EV_ILIM); settle(); chk_flag(irq, 1'b0);
    reg_write(OFF_STATUS, 32'hFFFFFFFF);
    reg_read(OFF_STATUS); chk_word(rd_val, 32'h1 << POS_ILIM | 32'h1 << POS_COMM);
    reg_read(8'h0C); chk_word(rd_val, 32'h0);
    $display("test irq done");
    complete_run();
  end
endmodule
